// ===== hw/acm_top.sv
/*
  Converter calibration loop, signal strength capture and test port.
  Assumes APB master on clk_i; converter and receiver status inputs are
  synchronous to clk_i except the converter codes and their valid strobes, which are resynchronised.
*/
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "acm_defines.svh"

// How it works
// RULE_01: Full scale on I or Q adds increment
// RULE_02: No full scale subtracts decrement step
// RULE_03: Top five accumulator bits drive references
// RULE_04: Reference output refreshed at one kHz
// RULE_05: Mode bit4 low holds mid scale
// RULE_06: Mode 10 accumulates only while tracking
// RULE_07: Mode 11 accumulates while receiver enabled
// RULE_08: Host presets off, then picks tracking
// RULE_09: Host balances steps for 33% saturation
// RULE_10: Strength captured six bits, readable both ways
// RULE_11: Captured strength feeds clear channel logic
// RULE_12: Eight-bit test bus plus strobe
// RULE_13: Select register picks bus; monitor mirrors
// RULE_14: Thirty-two modes; reserved show zero
// RULE_15: Mode 1 shows acquisition flags
// RULE_16: Mode 2 strobe marker, transmit starts
// RULE_17: Mode 3 strength sample and sense
// RULE_18: Receiver disabled means standby, no accumulation
// RULE_19: Accumulator saturates; off mode presets mid
// RULE_20: Mode 0 drives bus and strobe low
module acm_top import acm_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Converter samples
  input wire logic [2:0] i_code_i,
  input wire logic [2:0] q_code_i,
  input wire logic sample_valid_i,
  input wire logic [5:0] strength_code_i,
  input wire logic strength_valid_i,
  // Receiver and transmitter status
  input wire logic receive_enable_envelope_i,
  input wire acm_rx_stat_type rx_stat_i,
  input wire acm_tx_stat_type tx_stat_i,
  input wire logic internal_transmit_envelope_i,
  input wire logic iq_sample_marker_i,
  input wire logic carrier_sense_flag_i,
  input wire logic carrier_sense_latched_i,
  // Outputs
  output logic [4:0] ref_dac_o,
  output logic [5:0] cca_strength_o,
  output logic [7:0] test_bus_o,
  output logic test_strobe_out_o
);

  // ==========================================
  // Registers
  logic [7:0] receiver_config_reg_ff, nxt_receiver_config_reg;
  logic [23:0] cal_increment_step_ff, nxt_cal_increment_step;
  logic [23:0] cal_decrement_step_ff, nxt_cal_decrement_step;
  logic [4:0] test_select_reg_ff, nxt_test_select_reg;
  logic [7:0] test_monitor_reg_ff, nxt_test_monitor_reg;
  logic [23:0] acc_ff, nxt_acc;
  logic [4:0] ref_ff, nxt_ref;
  logic [14:0] tick_ff, nxt_tick;
  logic [5:0] strength_ff, nxt_strength;
  logic [7:0] bus_ff, nxt_bus;
  logic strobe_ff, nxt_strobe;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [5:0] i_sync1_ff, i_sync2_ff;
  logic [5:0] s_sync1_ff, s_sync2_ff;
  logic [1:0] v_sync1_ff, v_sync2_ff;
  acm_cal_mode_type mode;
  logic run;
  logic full_hit;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [24:0] sum;

  localparam logic [14:0] UPDATE_LAST = 15'(`ACM_UPDATE_CYC - 1);

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `ACM_OFF_RXCFG) || (a == `ACM_OFF_INC) || (a == `ACM_OFF_DEC) ||
      (a == `ACM_OFF_TSEL) || (a == `ACM_OFF_TMON) || (a == `ACM_OFF_CALACC) ||
      (a == `ACM_OFF_STRENGTH);
  endfunction

  function automatic logic is_full(input logic [2:0] c);
    is_full = (c == `ACM_FULL_POS) || (c == `ACM_FULL_NEG);
  endfunction

  // ==========================================
  // Pin synchronisers; converter codes arrive from the analog side
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      i_sync1_ff <= 6'h00;
      i_sync2_ff <= 6'h00;
      s_sync1_ff <= 6'h00;
      s_sync2_ff <= 6'h00;
      v_sync1_ff <= 2'h0;
      v_sync2_ff <= 2'h0;
    end else begin
      i_sync1_ff <= {i_code_i, q_code_i};
      i_sync2_ff <= i_sync1_ff;
      s_sync1_ff <= strength_code_i;
      s_sync2_ff <= s_sync1_ff;
      v_sync1_ff <= {sample_valid_i, strength_valid_i};
      v_sync2_ff <= v_sync1_ff;
    end
  end

  // ==========================================
  // APB decode, zero wait states
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign mapped = is_mapped(paddr_i);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o = rdata_ff;

  always_comb begin
    nxt_receiver_config_reg = receiver_config_reg_ff;
    nxt_cal_increment_step = cal_increment_step_ff;
    nxt_cal_decrement_step = cal_decrement_step_ff;
    nxt_test_select_reg = test_select_reg_ff;
    nxt_rdata = rdata_ff;
    if (wr_en) begin
      case (paddr_i)
        `ACM_OFF_RXCFG: nxt_receiver_config_reg = pwdata_i[7:0];
        `ACM_OFF_INC: nxt_cal_increment_step = pwdata_i[23:0];
        `ACM_OFF_DEC: nxt_cal_decrement_step = pwdata_i[23:0];
        // RULE_13: test select write
        `ACM_OFF_TSEL: nxt_test_select_reg = pwdata_i[4:0];
        default: nxt_rdata = rdata_ff;
      endcase
    end
    if (rd_en) begin
      case (paddr_i)
        `ACM_OFF_RXCFG: nxt_rdata = {24'h000000, receiver_config_reg_ff};
        `ACM_OFF_INC: nxt_rdata = {8'h00, cal_increment_step_ff};
        `ACM_OFF_DEC: nxt_rdata = {8'h00, cal_decrement_step_ff};
        `ACM_OFF_TSEL: nxt_rdata = {27'h0000000, test_select_reg_ff};
        // RULE_13: monitor mirrors bus
        `ACM_OFF_TMON: nxt_rdata = {24'h000000, test_monitor_reg_ff};
        `ACM_OFF_CALACC: nxt_rdata = {8'h00, acc_ff};
        // RULE_10: strength readable
        `ACM_OFF_STRENGTH: nxt_rdata = {26'h0000000, strength_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // Calibration loop
  always_comb begin
    // RULE_05: bit4 low is off regardless of bit3
    if (!receiver_config_reg_ff[`ACM_CFG_ENABLE_BIT]) begin
      mode = ACM_CAL_OFF;
    end else if (receiver_config_reg_ff[`ACM_CFG_TRACK_BIT]) begin
      mode = ACM_CAL_RXON;
    end else begin
      mode = ACM_CAL_TRACK;
    end
  end

  always_comb begin
    case (mode)
      // RULE_06: tracking only
      ACM_CAL_TRACK: run = receive_enable_envelope_i && rx_stat_i.tracking;
      // RULE_07: RULE_18: whole enable envelope
      ACM_CAL_RXON: run = receive_enable_envelope_i;
      ACM_CAL_OFF: run = 1'b0;
      default: run = 1'b0;
    endcase
  end

  assign full_hit = is_full(i_sync2_ff[5:3]) || is_full(i_sync2_ff[2:0]);

  always_comb begin
    nxt_acc = acc_ff;
    sum = 25'h0000000;
    nxt_tick = (tick_ff == UPDATE_LAST) ? 15'h0000 : tick_ff + 15'h0001;
    nxt_ref = ref_ff;
    if (mode == ACM_CAL_OFF) begin
      // RULE_19: off presets mid scale
      nxt_acc = `ACM_ACC_MID;
      nxt_ref = `ACM_REF_MID;
    end else begin
      if (run && v_sync2_ff[1]) begin
        if (full_hit) begin
          // RULE_01: add increment, saturate high
          sum = {1'b0, acc_ff} + {1'b0, cal_increment_step_ff};
          nxt_acc = sum[24] ? 24'hFFFFFF : sum[23:0];
        end else begin
          // RULE_02: subtract decrement, saturate low
          sum = {1'b0, acc_ff} - {1'b0, cal_decrement_step_ff};
          nxt_acc = sum[24] ? 24'h000000 : sum[23:0];
        end
      end
      // RULE_04: RULE_03: refresh top bits at 1 kHz
      if (tick_ff == UPDATE_LAST) begin
        nxt_ref = acc_ff[23:19];
      end
    end
  end

  assign ref_dac_o = ref_ff;

  // ==========================================
  // Strength capture and test port
  always_comb begin
    nxt_strength = strength_ff;
    // RULE_10: capture six-bit strength
    if (v_sync2_ff[0]) begin
      nxt_strength = s_sync2_ff;
    end
  end

  // RULE_11: feed clear channel logic
  assign cca_strength_o = strength_ff;

  always_comb begin
    nxt_bus = 8'h00;
    nxt_strobe = 1'b0;
    // RULE_14: unlisted and reserved modes read zero
    case (test_select_reg_ff)
      // RULE_20: quiet bus
      `ACM_TM_QUIET: nxt_bus = 8'h00;
      // RULE_15: acquisition flags
      `ACM_TM_RXACQ: begin
        nxt_strobe = rx_stat_i.initial_detect;
        nxt_bus = {3'h0, rx_stat_i.tracking, rx_stat_i.sfd_detect, rx_stat_i.signal_ready,
          rx_stat_i.length_ready, rx_stat_i.header_crc_valid};
      end
      // RULE_16: transmit field starts
      `ACM_TM_TXFLD: begin
        nxt_strobe = iq_sample_marker_i;
        nxt_bus = {run, internal_transmit_envelope_i, tx_stat_i.preamble_start,
          tx_stat_i.sfd_start, tx_stat_i.signal_start, 1'b0, tx_stat_i.crc_start,
          tx_stat_i.mpdu_start};
      end
      // RULE_17: strength monitor
      `ACM_TM_STRENGTH: begin
        nxt_strobe = v_sync2_ff[0];
        nxt_bus = {carrier_sense_latched_i, carrier_sense_flag_i, nxt_strength};
      end
      default: nxt_bus = 8'h00;
    endcase
    nxt_test_monitor_reg = nxt_bus;
  end

  // RULE_12: registered test outputs
  assign test_bus_o = bus_ff;
  assign test_strobe_out_o = strobe_ff;

  // ==========================================
  // State registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      receiver_config_reg_ff <= `ACM_RXCFG_RST;
      cal_increment_step_ff <= `ACM_STEP_RST;
      cal_decrement_step_ff <= `ACM_STEP_RST;
      test_select_reg_ff <= `ACM_TM_QUIET;
      test_monitor_reg_ff <= 8'h00;
      acc_ff <= `ACM_ACC_MID;
      ref_ff <= `ACM_REF_MID;
      tick_ff <= 15'h0000;
      strength_ff <= 6'h00;
      bus_ff <= 8'h00;
      strobe_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      receiver_config_reg_ff <= nxt_receiver_config_reg;
      cal_increment_step_ff <= nxt_cal_increment_step;
      cal_decrement_step_ff <= nxt_cal_decrement_step;
      test_select_reg_ff <= nxt_test_select_reg;
      test_monitor_reg_ff <= nxt_test_monitor_reg;
      acc_ff <= nxt_acc;
      ref_ff <= nxt_ref;
      tick_ff <= nxt_tick;
      strength_ff <= nxt_strength;
      bus_ff <= nxt_bus;
      strobe_ff <= nxt_strobe;
      rdata_ff <= nxt_rdata;
    end
  end

endmodule

// ===== hw/acm_defines.svh
/*
  Constants for the converter calibration, signal strength and test monitor block.
  Assumes a 25 MHz clock.
*/
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH

// ==========================================
// Register offsets (byte addresses)
`define ACM_OFF_RXCFG 12'h000
`define ACM_OFF_INC 12'h004
`define ACM_OFF_DEC 12'h008
`define ACM_OFF_TSEL 12'h00C
`define ACM_OFF_TMON 12'h010
`define ACM_OFF_CALACC 12'h014
`define ACM_OFF_STRENGTH 12'h018

// ==========================================
// Fields and reset values
`define ACM_CFG_TRACK_BIT 3
`define ACM_CFG_ENABLE_BIT 4
`define ACM_RXCFG_RST 8'h00
`define ACM_STEP_RST 24'h000001
`define ACM_ACC_MID 24'h800000
`define ACM_REF_MID 5'h10
`define ACM_FULL_POS 3'h7
`define ACM_FULL_NEG 3'h0

// ==========================================
// Timing
`define ACM_CLK_HZ 25000000
`define ACM_UPDATE_HZ 1000
`define ACM_UPDATE_CYC (`ACM_CLK_HZ / `ACM_UPDATE_HZ)

// ==========================================
// Test modes
`define ACM_TM_QUIET 5'h00
`define ACM_TM_RXACQ 5'h01
`define ACM_TM_TXFLD 5'h02
`define ACM_TM_STRENGTH 5'h03

`endif

// ===== hw/acm_pkg.sv
/*
  Types for the calibration and test monitor block.
  Assumes acm_defines.svh is available.
*/
package acm_pkg;

  // ==========================================
  // Status groups
  typedef struct packed {
    logic initial_detect;
    logic tracking;
    logic sfd_detect;
    logic signal_ready;
    logic length_ready;
    logic header_crc_valid;
  } acm_rx_stat_type;

  typedef struct packed {
    logic preamble_start;
    logic sfd_start;
    logic signal_start;
    logic crc_start;
    logic mpdu_start;
  } acm_tx_stat_type;

  typedef enum logic [2:0] {
    ACM_CAL_OFF = 3'b001,
    ACM_CAL_TRACK = 3'b010,
    ACM_CAL_RXON = 3'b100
  } acm_cal_mode_type;

endpackage

// ===== bench/acm_chk.sv
/*
  Port checker for acm_top.
  Assumes one clock domain and a bind onto acm_top.
*/
`timescale 1ns/1ps
`include "acm_defines.svh"
module acm_chk import acm_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Status and outputs
  input wire logic internal_transmit_envelope_i,
  input wire logic iq_sample_marker_i,
  input wire logic carrier_sense_flag_i,
  input wire logic carrier_sense_latched_i,
  input wire logic [4:0] ref_dac_o,
  input wire logic [5:0] cca_strength_o,
  input wire logic [7:0] test_bus_o,
  input wire logic test_strobe_out_o
);
  // ==========================================
  // Shadow copies, delayed once to match registered outputs
  logic [4:0] tsel_ff;
  logic [4:0] tsel_d_ff;
  logic off_ff;
  logic off_d_ff;
  logic bad;
  logic wr;
  assign bad = (paddr_i > `ACM_OFF_STRENGTH) || (paddr_i[1:0] != 2'b00);
  assign wr = psel_i && penable_i && pwrite_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tsel_ff <= 5'h00;
      tsel_d_ff <= 5'h00;
      off_ff <= 1'b1;
      off_d_ff <= 1'b1;
    end else begin
      if (wr && paddr_i == `ACM_OFF_TSEL)
        tsel_ff <= pwdata_i[4:0];
      if (wr && paddr_i == `ACM_OFF_RXCFG)
        off_ff <= !pwdata_i[`ACM_CFG_ENABLE_BIT];
      tsel_d_ff <= tsel_ff;
      off_d_ff <= off_ff;
    end
  end
  // ==========================================
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence acc_s;
    psel_i && penable_i;
  endsequence
  sequence rd_s(logic [11:0] a);
    psel_i && penable_i && !pwrite_i && paddr_i == a;
  endsequence
  ready_always_a: assert property (acc_s |-> pready_o)
    else $error("pready low in access");
  err_unmapped_a: assert property (acc_s |-> pslverr_o == bad)
    else $error("pslverr wrong");
  rd_unmapped_a: assert property (acc_s ##0 (!pwrite_i && bad) |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  mon_read_a: assert property (rd_s(`ACM_OFF_TMON) |-> prdata_o == {24'h0, $past(test_bus_o)})
    else $error("monitor differs from bus");
  str_read_a: assert property (rd_s(`ACM_OFF_STRENGTH) |-> prdata_o == {26'h0, $past(cca_strength_o)})
    else $error("strength read differs");
  quiet_bus_a: assert property (tsel_d_ff == 5'h00 |-> test_bus_o == 8'h00 && !test_strobe_out_o)
    else $error("quiet mode not low");
  reserved_bus_a: assert property (tsel_d_ff > 5'h03 |-> test_bus_o == 8'h00 && !test_strobe_out_o)
    else $error("reserved mode not low");
  tx_field_a: assert property (tsel_d_ff == 5'h02 |-> test_bus_o[6] == $past(internal_transmit_envelope_i)
    && test_strobe_out_o == $past(iq_sample_marker_i))
    else $error("transmit mode bus wrong");
  sense_bits_a: assert property (tsel_d_ff == 5'h03 |->
    test_bus_o[7:6] == $past({carrier_sense_latched_i, carrier_sense_flag_i}))
    else $error("sense flags wrong");
  off_mid_a: assert property (off_ff && off_d_ff |-> ref_dac_o == `ACM_REF_MID)
    else $error("off mode not mid scale");
endmodule
bind acm_top acm_chk i_chk (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .internal_transmit_envelope_i, .iq_sample_marker_i, .carrier_sense_flag_i,
  .carrier_sense_latched_i, .ref_dac_o, .cca_strength_o, .test_bus_o, .test_strobe_out_o);

// ===== bench/acm_conv_model.sv
/*
  Converter side model: I/Q codes and strength samples.
  Assumes the caller drives it from the bench clock.
*/
`timescale 1ns/1ps
module acm_conv_model (
  // Clock
  input wire logic clk_i,
  // Converter outputs
  output logic [2:0] i_code_o,
  output logic [2:0] q_code_o,
  output logic sample_valid_o,
  output logic [5:0] strength_code_o,
  output logic strength_valid_o
);
  // ==========================================
  // Sample tasks; codes change after the hold so stale values never linger
  initial begin
    i_code_o = 3'h3;
    q_code_o = 3'h4;
    sample_valid_o = 1'b0;
    strength_code_o = 6'h00;
    strength_valid_o = 1'b0;
  end
  task automatic sample(input logic [2:0] i, input logic [2:0] q);
    @(posedge clk_i);
    i_code_o <= i;
    q_code_o <= q;
    sample_valid_o <= 1'b1;
    @(posedge clk_i);
    sample_valid_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    i_code_o <= ~i;
    q_code_o <= ~q;
  endtask
  task automatic strength(input logic [5:0] s);
    @(posedge clk_i);
    strength_code_o <= s;
    strength_valid_o <= 1'b1;
    @(posedge clk_i);
    strength_valid_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    strength_code_o <= ~s;
  endtask
endmodule

// ===== bench/tb.sv
/*
  Testbench for acm_top: APB tasks and scripted checks.
  Assumes acm_conv_model and the bound checker.
*/
`timescale 1ns/1ps
`include "acm_defines.svh"
module tb import acm_pkg::*;;
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic env, tx_env, iq_mark, cs, cs_lat, sv, strv, tstb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] icode, qcode;
  logic [5:0] strc, cca;
  logic [4:0] ref_dac;
  logic [7:0] tbus;
  logic [4:0] qm [3] = '{5'h00, 5'h0B, 5'h1F};
  acm_rx_stat_type rx_stat;
  acm_tx_stat_type tx_stat;
  int error_cnt, n_tests, cyc;
  acm_conv_model p (.clk_i(clk_i), .i_code_o(icode), .q_code_o(qcode), .sample_valid_o(sv),
    .strength_code_o(strc), .strength_valid_o(strv));
  acm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .i_code_i(icode), .q_code_i(qcode), .sample_valid_i(sv), .strength_code_i(strc), .strength_valid_i(strv),
    .receive_enable_envelope_i(env), .rx_stat_i(rx_stat), .tx_stat_i(tx_stat),
    .internal_transmit_envelope_i(tx_env), .iq_sample_marker_i(iq_mark), .carrier_sense_flag_i(cs),
    .carrier_sense_latched_i(cs_lat), .ref_dac_o(ref_dac), .cca_strength_o(cca), .test_bus_o(tbus),
    .test_strobe_out_o(tstb));
  // ==========================================
  // Clock, timeout, report
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ==========================================
  // APB master: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic burst();
    p.sample(3'h7, 3'h3);
    p.sample(3'h3, 3'h0);
    p.sample(3'h3, 3'h4);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {cyc, error_cnt, n_tests} = '0;
    {rst_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {env, tx_env, iq_mark, cs, cs_lat, rx_stat, tx_stat} = {5'b00001, 11'h000};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({27'h0, ref_dac}, 32'h10); // mid scale at reset
    rd_chk(`ACM_OFF_CALACC, 32'h800000); // mid scale at reset
    apb(1'b1, `ACM_OFF_INC, 32'h2); // steps for one third
    apb(1'b1, `ACM_OFF_DEC, 32'h1); // steps for one third
    apb(1'b1, `ACM_OFF_RXCFG, 32'h00); // preset first
    apb(1'b1, `ACM_OFF_RXCFG, 32'h18); // run while enabled
    env <= 1'b1;
    burst(); // two hits, one miss
    rd_chk(`ACM_OFF_CALACC, 32'h800003); // up, up, down
    env <= 1'b0;
    burst(); // samples while disabled
    rd_chk(`ACM_OFF_CALACC, 32'h800003); // frozen while disabled
    apb(1'b1, `ACM_OFF_RXCFG, 32'h10); // tracking only
    env <= 1'b1;
    burst(); // samples while not tracking
    rd_chk(`ACM_OFF_CALACC, 32'h800003); // frozen when not tracking
    rx_stat.tracking <= 1'b1;
    burst(); // samples while tracking
    rd_chk(`ACM_OFF_CALACC, 32'h800006); // runs while tracking
    apb(1'b1, `ACM_OFF_RXCFG, 32'h08); // bit3 set, bit4 clear
    rd_chk(`ACM_OFF_CALACC, 32'h800000); // off preset
    chk({27'h0, ref_dac}, 32'h10); // reference at mid scale
    apb(1'b1, `ACM_OFF_RXCFG, 32'h18); // run while enabled
    apb(1'b1, `ACM_OFF_DEC, 32'hFFFFFF); // step past floor
    p.sample(3'h3, 3'h3); // miss
    rd_chk(`ACM_OFF_CALACC, 32'h0); // floor holds
    apb(1'b1, `ACM_OFF_INC, 32'hFFFFFF); // step to ceiling
    p.sample(3'h7, 3'h7); // hit reaches ceiling
    p.sample(3'h7, 3'h7); // hit past ceiling
    rd_chk(`ACM_OFF_CALACC, 32'hFFFFFF); // ceiling holds
    for (int k = 0; k < 26000 && ref_dac !== 5'h1F; k++) @(posedge clk_i);
    chk({27'h0, ref_dac}, 32'h1F); // top bits after update
    p.strength(6'h2A); // one strength sample
    apb(1'b1, `ACM_OFF_TSEL, 32'h3); // strength mode
    repeat (3) @(posedge clk_i);
    chk({24'h0, tbus}, 32'hAA); // strength on bus
    rd_chk(`ACM_OFF_TMON, 32'hAA); // monitor mirrors bus
    rd_chk(`ACM_OFF_STRENGTH, 32'h2A); // captured strength
    chk({26'h0, cca}, 32'h2A); // strength to channel logic
    {tx_env, iq_mark, rx_stat, tx_stat} <= {2'b11, 6'h36, 5'h15};
    apb(1'b1, `ACM_OFF_TSEL, 32'h2); // transmit field mode
    repeat (2) @(posedge clk_i);
    chk({23'h0, tstb, tbus}, 32'h1E9); // marker and transmit fields
    rd_chk(`ACM_OFF_TMON, 32'hE9); // monitor in transmit mode
    apb(1'b1, `ACM_OFF_TSEL, 32'h1); // acquisition mode
    repeat (2) @(posedge clk_i);
    chk({23'h0, tstb, tbus}, 32'h116); // detect strobe and flags
    rd_chk(`ACM_OFF_TMON, 32'h16); // monitor in acquisition mode
    foreach (qm[m]) begin
      apb(1'b1, `ACM_OFF_TSEL, {27'h0, qm[m]}); // quiet and reserved
      repeat (2) @(posedge clk_i);
      rd_chk(`ACM_OFF_TMON, 32'h0); // quiet and reserved
    end
    rd_chk(12'h01C, 32'h0); // unmapped reads zero
    end_of_test();
  end
endmodule
